//--- dsi_resp_regs.svh
// Constants for the response and error-report packet layer.
// Assumes inclusion by the package, the design and the checker files only.
`ifndef DSI_RESP_REGS_SVH
`define DSI_RESP_REGS_SVH

// Identifier byte fields
`define VC_RESP 2'h0
`define DT_ACK_ERROR_REPORT 6'h02
`define DT_CMDSET_LONG_READ_RESP 6'h1c
`define DT_CMDSET_SHORT_READ_RESP_1B 6'h21
`define DT_CMDSET_SHORT_READ_RESP_2B 6'h22
`define DT_GENERIC_LONG_READ_RESP 6'h1a
`define DT_GENERIC_SHORT_READ_RESP_1B 6'h11
`define DT_GENERIC_SHORT_READ_RESP_2B 6'h12

// Pixel stream data types, plain defaults
`define DT_PIX18_LOOSE 6'h1e
`define DT_PIX24 6'h3e

// Error report bit positions
`define ERR_ECC_SINGLE 8
`define ERR_ECC_MULTI 9
`define ERR_CHECKSUM 10
`define ERR_RESERVED 14

// Errors that make the packet unusable
`define ERR_DISCARD_MASK 16'hba00
// Errors that the link error counter counts
`define ERR_COUNT_MASK 16'h0700

// Response sizing
`define RSP_MAX_BYTES 4'h8
`define RSP_LEN_W 4
`define CNT_W 8
`define CNT_MAX 8'hff

`endif

//--- dsi_resp_pkg.sv
// Types shared by the response and error-report packet layer.
// Assumes dsi_resp_regs.svh sits in the include path.
`include "dsi_resp_regs.svh"

package dsi_resp_pkg;

  // Received packet header, already ECC checked
  typedef struct packed {
    logic [1:0] vc;
    logic [5:0] dt;
    logic [15:0] wc;
    logic long_pkt;
  } rx_hdr_t;

  // One decoded pixel; 18-bit components sit in the low six bits
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_t;

  // One outgoing response byte with framing marks
  typedef struct packed {
    logic first;
    logic last;
    logic long_pkt;
    logic [7:0] data;
  } tx_byte_t;

  // Response sequencer states, Gray coded along the long-packet path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DI = 3'b001,
    ST_W0 = 3'b011,
    ST_W1 = 3'b010,
    ST_PAY = 3'b110,
    ST_DONE = 3'b111
  } rsp_state_t;

endpackage : dsi_resp_pkg

//--- sync3.sv
// Three-stage synchroniser with agreement filter.
// Assumes the input is a level from another clock domain.
`timescale 1ns/1ps

module sync3 #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous level in, filtered level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // First stage feeds only the second, to contain metastability
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change is taken only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else if (s2_reg == s3_reg) begin
      q_o <= s3_reg;
    end
  end

endmodule : sync3

//--- dsi_resp_framer.sv
// Pixel stream decoder, error report keeper and response framer.
// Assumes a lower layer that checks header ECC, flags lane errors,
// checks the payload checksum, and appends ECC and checksum bytes
// to outgoing packets using the framing marks of tx_o.
`timescale 1ns/1ps
`include "dsi_resp_regs.svh"

module dsi_resp_framer #(
  parameter logic [5:0] PIX18_DT = `DT_PIX18_LOOSE,
  parameter logic [5:0] PIX24_DT = `DT_PIX24
) (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Link clock from the receiver
  input wire logic link_clk_i,
  // Received packets, link domain
  input wire logic rx_hdr_valid_i,
  input wire dsi_resp_pkg::rx_hdr_t rx_hdr_i,
  input wire logic [15:0] rx_hdr_err_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_bad_i,
  // Decoded pixels, link domain
  output logic pix_valid_o,
  output dsi_resp_pkg::pixel_t pix_o,
  output logic pix_fmt18_o,
  output logic pix_drop_o,
  // Response requests, core domain
  input wire logic rsp_req_i,
  input wire logic rsp_generic_i,
  input wire logic [`RSP_LEN_W-1:0] rsp_len_i,
  input wire logic [63:0] rsp_data_i,
  input wire logic ack_req_i,
  input wire logic cnt_read_i,
  output logic rsp_busy_o,
  // Response byte stream, core domain
  output logic tx_valid_o,
  output dsi_resp_pkg::tx_byte_t tx_o,
  input wire logic tx_ready_i,
  // Error status, core domain
  output logic err_flag_o,
  output logic [`CNT_W-1:0] err_count_o,
  output logic [15:0] err_report_o
);

  // Link-domain state
  logic rst_link;
  dsi_resp_pkg::rx_hdr_t hdr_reg;
  logic in_pkt_reg;
  logic discard_reg;
  logic [15:0] err_acc_reg;
  logic [15:0] report_hold_reg;
  logic report_tog_reg;
  logic [1:0] slot_reg;
  logic [7:0] red_reg;
  logic [7:0] green_reg;
  logic pix_pkt;
  logic [7:0] comp;
  logic [15:0] hdr_err;

  // Core-domain state
  logic tog_sync;
  logic tog_seen_reg;
  logic report_ev;
  logic [15:0] new_report;
  dsi_resp_pkg::rsp_state_t st_reg;
  dsi_resp_pkg::rsp_state_t st_next;
  logic [5:0] dt_reg;
  logic long_reg;
  logic [`RSP_LEN_W-1:0] len_reg;
  logic [63:0] data_reg;
  logic [`RSP_LEN_W-1:0] idx_reg;
  logic ack_pend_reg;
  logic advance;
  dsi_resp_pkg::tx_byte_t tx_next;

  // Reset reaches the link domain through the synchroniser; the
  // link clock must run for a few edges while reset is held
  sync3 #(.W(1)) u_rst_sync (
    .clk_i(link_clk_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(rst_link)
  );

  // Header flags cleaned: reserved bit never set, checksum bit
  // only comes from the payload check
  always_comb begin
    hdr_err = rx_hdr_err_i;
    hdr_err[`ERR_RESERVED] = 1'b0;
    hdr_err[`ERR_CHECKSUM] = 1'b0;
  end

  // Packet framing and error collection on the link side
  always_ff @(posedge link_clk_i) begin
    if (rst_link) begin
      hdr_reg <= '0;
      in_pkt_reg <= 1'b0;
      discard_reg <= 1'b0;
      err_acc_reg <= 16'h0000;
    end else if (rx_hdr_valid_i) begin
      // Each header starts a fresh report, older errors drop out
      hdr_reg <= rx_hdr_i;
      in_pkt_reg <= rx_hdr_i.long_pkt;
      discard_reg <= |(hdr_err & `ERR_DISCARD_MASK);
      err_acc_reg <= hdr_err;
    end else if (rx_end_i) begin
      in_pkt_reg <= 1'b0;
    end
  end

  // Finished report is held still while it crosses over
  always_ff @(posedge link_clk_i) begin
    if (rst_link) begin
      report_hold_reg <= 16'h0000;
      report_tog_reg <= 1'b0;
    end else if (rx_hdr_valid_i && !rx_hdr_i.long_pkt) begin
      report_hold_reg <= hdr_err;
      report_tog_reg <= ~report_tog_reg;
    end else if (rx_end_i && in_pkt_reg) begin
      report_hold_reg <= err_acc_reg |
        (rx_crc_bad_i ? 16'h0400 : 16'h0000);
      report_tog_reg <= ~report_tog_reg;
    end
  end

  // Only pixel packets without a discard-mask error feed the panel
  assign pix_pkt = in_pkt_reg && !discard_reg &&
    (hdr_reg.dt == PIX18_DT || hdr_reg.dt == PIX24_DT);

  // Loose 18-bit uses the upper six bits of each byte; bytes
  // arrive already assembled, least significant bit first
  assign comp = (hdr_reg.dt == PIX18_DT) ?
    {2'b00, rx_byte_i[7:2]} : rx_byte_i;

  // Component slot walks red, green, blue
  always_ff @(posedge link_clk_i) begin
    if (rst_link) begin
      slot_reg <= 2'h0;
      red_reg <= 8'h00;
      green_reg <= 8'h00;
    end else if (rx_hdr_valid_i) begin
      slot_reg <= 2'h0;
    end else if (rx_byte_valid_i && pix_pkt) begin
      case (slot_reg)
        2'h0: begin
          red_reg <= comp;
          slot_reg <= 2'h1;
        end
        2'h1: begin
          green_reg <= comp;
          slot_reg <= 2'h2;
        end
        default: begin
          slot_reg <= 2'h0;
        end
      endcase
    end
  end

  // Pixel out on its blue byte; a partial pixel at packet end is
  // lost, which is why the host pads lines to three bytes
  always_ff @(posedge link_clk_i) begin
    if (rst_link) begin
      pix_valid_o <= 1'b0;
      pix_o <= '0;
      pix_fmt18_o <= 1'b0;
    end else begin
      pix_valid_o <= rx_byte_valid_i && pix_pkt &&
        slot_reg == 2'h2;
      if (rx_byte_valid_i && pix_pkt && slot_reg == 2'h2) begin
        pix_o <= '{red: red_reg, green: green_reg, blue: comp};
        pix_fmt18_o <= hdr_reg.dt == PIX18_DT;
      end
    end
  end

  // Checksum failure known only at the end; consumer drops line
  always_ff @(posedge link_clk_i) begin
    if (rst_link) begin
      pix_drop_o <= 1'b0;
    end else begin
      pix_drop_o <= rx_end_i && pix_pkt && rx_crc_bad_i;
    end
  end

  // Report toggle crosses to the core clock
  sync3 #(.W(1)) u_tog_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(report_tog_reg),
    .q_o(tog_sync)
  );

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tog_seen_reg <= 1'b0;
    end else begin
      tog_seen_reg <= tog_sync;
    end
  end

  assign report_ev = tog_sync != tog_seen_reg;
  // Hold register is stable for many core cycles by now
  assign new_report = report_hold_reg;

  // Latest report replaces the old one whole
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      err_report_o <= 16'h0000;
    end else if (report_ev) begin
      err_report_o <= new_report;
    end
  end

  // Sticky error flag; a new error wins over a read clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      err_flag_o <= 1'b0;
    end else if (report_ev && |new_report) begin
      err_flag_o <= 1'b1;
    end else if (cnt_read_i) begin
      err_flag_o <= 1'b0;
    end
  end

  // Errored packet counter, cleared by a read, sticks at full
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      err_count_o <= '0;
    end else if (cnt_read_i) begin
      err_count_o <= (report_ev && |(new_report & `ERR_COUNT_MASK))
        ? `CNT_W'(1) : '0;
    end else if (report_ev && |(new_report & `ERR_COUNT_MASK) &&
                 err_count_o != `CNT_MAX) begin
      err_count_o <= err_count_o + `CNT_W'(1);
    end
  end

  // Sequencer moves one byte whenever the output slot is free
  assign advance = st_reg != dsi_resp_pkg::ST_IDLE &&
    st_reg != dsi_resp_pkg::ST_DONE && (!tx_valid_o || tx_ready_i);

  // Next byte and state of the response packet
  always_comb begin
    tx_next = '0;
    tx_next.long_pkt = long_reg;
    st_next = st_reg;
    case (st_reg)
      dsi_resp_pkg::ST_DI: begin
        tx_next.first = 1'b1;
        tx_next.data = {`VC_RESP, dt_reg};
        st_next = dsi_resp_pkg::ST_W0;
      end
      dsi_resp_pkg::ST_W0: begin
        // Long: word count low byte; short: first data byte
        tx_next.data = long_reg ? {4'h0, len_reg} : data_reg[7:0];
        st_next = dsi_resp_pkg::ST_W1;
      end
      dsi_resp_pkg::ST_W1: begin
        if (long_reg) begin
          tx_next.data = 8'h00;
          tx_next.last = len_reg == '0;
          st_next = (len_reg == '0) ? dsi_resp_pkg::ST_DONE :
            dsi_resp_pkg::ST_PAY;
        end else begin
          tx_next.data = (len_reg == `RSP_LEN_W'(1)) ?
            8'h00 : data_reg[15:8];
          tx_next.last = 1'b1;
          st_next = dsi_resp_pkg::ST_DONE;
        end
      end
      dsi_resp_pkg::ST_PAY: begin
        tx_next.data = data_reg[idx_reg[2:0]*8 +: 8];
        tx_next.last = idx_reg == len_reg - `RSP_LEN_W'(1);
        if (tx_next.last) begin
          st_next = dsi_resp_pkg::ST_DONE;
        end
      end
      default: begin
        st_next = st_reg;
      end
    endcase
  end

  // Packet kind, type code and payload are chosen at the request
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= dsi_resp_pkg::ST_IDLE;
      dt_reg <= 6'h00;
      long_reg <= 1'b0;
      len_reg <= '0;
      data_reg <= 64'h0;
      ack_pend_reg <= 1'b0;
    end else begin
      case (st_reg)
        dsi_resp_pkg::ST_IDLE: begin
          if (rsp_req_i) begin
            // Up to the maximum all bytes go in one packet
            st_reg <= dsi_resp_pkg::ST_DI;
            data_reg <= rsp_data_i;
            len_reg <= (rsp_len_i > `RSP_MAX_BYTES) ?
              `RSP_MAX_BYTES : rsp_len_i;
            long_reg <= rsp_len_i > `RSP_LEN_W'(2);
            ack_pend_reg <= err_report_o[`ERR_ECC_SINGLE];
            if (rsp_len_i == `RSP_LEN_W'(1)) begin
              dt_reg <= rsp_generic_i ?
                `DT_GENERIC_SHORT_READ_RESP_1B :
                `DT_CMDSET_SHORT_READ_RESP_1B;
            end else if (rsp_len_i == `RSP_LEN_W'(2)) begin
              dt_reg <= rsp_generic_i ?
                `DT_GENERIC_SHORT_READ_RESP_2B :
                `DT_CMDSET_SHORT_READ_RESP_2B;
            end else begin
              dt_reg <= rsp_generic_i ?
                `DT_GENERIC_LONG_READ_RESP :
                `DT_CMDSET_LONG_READ_RESP;
            end
          end else if (ack_req_i) begin
            st_reg <= dsi_resp_pkg::ST_DI;
            dt_reg <= `DT_ACK_ERROR_REPORT;
            long_reg <= 1'b0;
            len_reg <= `RSP_LEN_W'(2);
            data_reg <= {48'h0, err_report_o};
            ack_pend_reg <= 1'b0;
          end
        end
        dsi_resp_pkg::ST_DONE: begin
          // Wait for the last byte to leave before the next packet
          if (!tx_valid_o || tx_ready_i) begin
            if (ack_pend_reg) begin
              st_reg <= dsi_resp_pkg::ST_DI;
              dt_reg <= `DT_ACK_ERROR_REPORT;
              long_reg <= 1'b0;
              len_reg <= `RSP_LEN_W'(2);
              data_reg <= {48'h0, err_report_o};
              ack_pend_reg <= 1'b0;
            end else begin
              st_reg <= dsi_resp_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          if (advance) begin
            st_reg <= st_next;
          end
        end
      endcase
    end
  end

  // Payload index
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      idx_reg <= '0;
    end else if (st_reg == dsi_resp_pkg::ST_DI) begin
      idx_reg <= '0;
    end else if (advance && st_reg == dsi_resp_pkg::ST_PAY) begin
      idx_reg <= idx_reg + `RSP_LEN_W'(1);
    end
  end

  // Output byte register holds until the lower layer takes it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_o <= '0;
    end else if (advance) begin
      tx_valid_o <= 1'b1;
      tx_o <= tx_next;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // Busy from request until the last packet has fully left
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rsp_busy_o <= 1'b0;
    end else if (st_reg == dsi_resp_pkg::ST_IDLE) begin
      rsp_busy_o <= rsp_req_i || ack_req_i;
    end else if (st_reg == dsi_resp_pkg::ST_DONE && !ack_pend_reg &&
                 (!tx_valid_o || tx_ready_i)) begin
      rsp_busy_o <= 1'b0;
    end
  end

endmodule : dsi_resp_framer

//--- dsi_resp_framer_props.sv
// Port checker for the response and error-report framer.
// Assumes it is bound onto every dsi_resp_framer instance.
`timescale 1ns/1ps
`include "dsi_resp_regs.svh"
module dsi_resp_framer_props (
  // Clocks and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  // Response side
  input wire logic rsp_req_i,
  input wire logic ack_req_i,
  input wire logic cnt_read_i,
  input wire logic rsp_busy_o,
  input wire logic tx_valid_o,
  input wire dsi_resp_pkg::tx_byte_t tx_o,
  input wire logic tx_ready_i,
  // Error status and pixels
  input wire logic err_flag_o,
  input wire logic [`CNT_W-1:0] err_count_o,
  input wire logic [15:0] err_report_o,
  input wire logic pix_valid_o,
  input wire dsi_resp_pkg::pixel_t pix_o,
  input wire logic pix_fmt18_o
);
  // Reply framing seen at the byte stream
  chk_req_answer: assert property (@(posedge core_clk_i)
    disable iff (rst_i) rsp_req_i && !rsp_busy_o
    |=> rsp_busy_o ##1 tx_valid_o && tx_o.first)
    else $error("read reply did not start on time");
  chk_ack_answer: assert property (@(posedge core_clk_i)
    disable iff (rst_i) ack_req_i && !rsp_req_i && !rsp_busy_o
    |-> ##2 tx_valid_o && tx_o.data == 8'h02)
    else $error("error report did not start on time");
  chk_tx_hold: assert property (@(posedge core_clk_i)
    disable iff (rst_i) tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_o))
    else $error("reply byte changed while stalled");
  chk_di_chan: assert property (@(posedge core_clk_i)
    disable iff (rst_i) tx_valid_o && tx_o.first |-> tx_o.data[7:6] == 2'h0)
    else $error("identifier channel not zero");
  chk_kind_match: assert property (@(posedge core_clk_i)
    disable iff (rst_i) tx_valid_o && tx_o.first
    |-> tx_o.long_pkt == (tx_o.data[5:0] inside {6'h1a, 6'h1c}))
    else $error("packet kind does not match data type");
  // Error status keeping
  chk_rsv_zero: assert property (@(posedge core_clk_i)
    disable iff (rst_i) err_report_o[14] == 1'b0)
    else $error("reserved report bit set");
  chk_cnt_step: assert property (@(posedge core_clk_i)
    disable iff (rst_i) !cnt_read_i
    |=> err_count_o - $past(err_count_o) <= 8'h1)
    else $error("error count jumped");
  chk_cnt_sat: assert property (@(posedge core_clk_i)
    disable iff (rst_i) err_count_o == 8'hff && !cnt_read_i
    |=> err_count_o == 8'hff)
    else $error("error count wrapped");
  chk_read_clear: assert property (@(posedge core_clk_i)
    disable iff (rst_i) cnt_read_i |=> err_count_o <= 8'h1)
    else $error("count not cleared by read");
  chk_flag_cnt: assert property (@(posedge core_clk_i)
    disable iff (rst_i) err_count_o != 8'h0 |-> err_flag_o)
    else $error("counted error without flag");
  // Pixel pacing and loose range, link side
  chk_pix_gap: assert property (@(posedge link_clk_i)
    disable iff (rst_i) pix_valid_o |=> !pix_valid_o ##1 !pix_valid_o)
    else $error("pixels closer than three bytes");
  chk_pix18_range: assert property (@(posedge link_clk_i)
    disable iff (rst_i) pix_valid_o && pix_fmt18_o
    |-> {pix_o.red[7:6], pix_o.green[7:6], pix_o.blue[7:6]} == 6'h0)
    else $error("loose pixel wider than six bits");
  // Main scenarios reached
  cov_sat: cover property (@(posedge core_clk_i) err_count_o == 8'hff);
  cov_stall: cover property (@(posedge core_clk_i) tx_valid_o && !tx_ready_i);
  cov_pix18: cover property (@(posedge link_clk_i) pix_valid_o && pix_fmt18_o);
endmodule : dsi_resp_framer_props

bind dsi_resp_framer dsi_resp_framer_props u_props (.core_clk_i, .rst_i,
  .link_clk_i, .rsp_req_i, .ack_req_i, .cnt_read_i, .rsp_busy_o,
  .tx_valid_o, .tx_o, .tx_ready_i, .err_flag_o, .err_count_o,
  .err_report_o, .pix_valid_o, .pix_o, .pix_fmt18_o);

//--- host_model.sv
// Host side model: sends link packets and reads reply bytes.
// Assumes the bench owns both clocks and calls send_pkt.
`timescale 1ns/1ps
module host_model (
  // Clocks and pacing
  input wire logic link_clk_i,
  input wire logic core_clk_i,
  input wire logic slow_i,
  output logic tx_ready_o,
  // Link packets
  output logic rx_hdr_valid_o,
  output dsi_resp_pkg::rx_hdr_t rx_hdr_o,
  output logic [15:0] rx_hdr_err_o,
  output logic rx_byte_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_end_o,
  output logic rx_crc_bad_o
);
  logic [1:0] phase_reg = 2'h0;
  // Idle link at time zero
  initial begin
    {rx_hdr_valid_o, rx_byte_valid_o, rx_end_o, rx_crc_bad_o} = 4'h0;
    {rx_hdr_o, rx_hdr_err_o, rx_byte_o} = '0;
    tx_ready_o = 1'b1;
  end
  // Slow reader takes one byte in four, to stall the framer
  always @(posedge core_clk_i) begin
    #1;
    phase_reg = phase_reg + 2'h1;
    tx_ready_o = !slow_i || phase_reg == 2'h3;
  end
  // Header, then for long packets word-count bytes and end mark; released lines inverted
  task automatic send_pkt(input dsi_resp_pkg::rx_hdr_t h,
      input logic [15:0] e, input logic [63:0] d, input logic bad);
    @(posedge link_clk_i);
    #1;
    rx_hdr_valid_o = 1'b1;
    rx_hdr_o = h;
    rx_hdr_err_o = e;
    @(posedge link_clk_i);
    #1;
    rx_hdr_valid_o = 1'b0;
    rx_hdr_o = ~h;
    rx_hdr_err_o = ~e;
    if (h.long_pkt) begin
      for (int i = 0; i < h.wc; i++) begin
        rx_byte_valid_o = 1'b1;
        rx_byte_o = d[8*i+:8];
        @(posedge link_clk_i);
        #1;
      end
      rx_byte_valid_o = 1'b0;
      rx_byte_o = ~rx_byte_o;
      rx_end_o = 1'b1;
      rx_crc_bad_o = bad;
      @(posedge link_clk_i);
      #1;
      rx_end_o = 1'b0;
      rx_crc_bad_o = ~bad;
    end
    repeat (4) @(posedge link_clk_i);
  endtask : send_pkt
endmodule : host_model

//--- tb_top.sv
// Self-checking bench for the response and error-report framer.
// Assumes package, design, checker and host model compiled first.
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i, link_clk_i, rst_i, slow;
  logic rx_hdr_valid_i, rx_byte_valid_i, rx_end_i, rx_crc_bad_i;
  dsi_resp_pkg::rx_hdr_t rx_hdr_i;
  logic [15:0] rx_hdr_err_i, err_report_o, r;
  logic [7:0] rx_byte_i, err_count_o;
  logic pix_valid_o, pix_fmt18_o, pix_drop_o, rsp_busy_o, tx_valid_o;
  dsi_resp_pkg::pixel_t pix_o;
  dsi_resp_pkg::tx_byte_t tx_o;
  logic rsp_req_i, rsp_generic_i, ack_req_i, cnt_read_i, tx_ready_i;
  logic err_flag_o;
  logic [3:0] rsp_len_i;
  logic [63:0] rsp_data_i, dat;
  logic [31:0] lfsr_reg = 32'h00012993;
  logic [9:0] txq[$], expq[$];
  logic [24:0] pixq[$];
  int fail_count = 0, n_compared = 0, n_drop = 0, b, g, n, i;

  dsi_resp_framer i_dsi_resp_framer (.core_clk_i, .rst_i, .link_clk_i,
    .rx_hdr_valid_i, .rx_hdr_i, .rx_hdr_err_i, .rx_byte_valid_i,
    .rx_byte_i, .rx_end_i, .rx_crc_bad_i, .pix_valid_o, .pix_o,
    .pix_fmt18_o, .pix_drop_o, .rsp_req_i, .rsp_generic_i, .rsp_len_i,
    .rsp_data_i, .ack_req_i, .cnt_read_i, .rsp_busy_o, .tx_valid_o,
    .tx_o, .tx_ready_i, .err_flag_o, .err_count_o, .err_report_o);
  host_model u_host (.link_clk_i, .core_clk_i, .slow_i(slow),
    .tx_ready_o(tx_ready_i), .rx_hdr_valid_o(rx_hdr_valid_i),
    .rx_hdr_o(rx_hdr_i), .rx_hdr_err_o(rx_hdr_err_i),
    .rx_byte_valid_o(rx_byte_valid_i), .rx_byte_o(rx_byte_i),
    .rx_end_o(rx_end_i), .rx_crc_bad_o(rx_crc_bad_i));

  // Unrelated clocks: 5 ns core, 30 ns link
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  // Monitors of taken reply bytes, pixels and drop pulses
  always @(posedge core_clk_i) begin
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      txq.push_back({tx_o.first, tx_o.last, tx_o.data});
  end
  always @(posedge link_clk_i) begin
    if (pix_valid_o === 1'b1) pixq.push_back({pix_fmt18_o, pix_o});
    if (pix_drop_o === 1'b1) n_drop++;
  end

  function automatic logic [31:0] rnd();
    lfsr_reg = {lfsr_reg[30:0], ^(lfsr_reg & 32'h80200003)};
    return lfsr_reg;
  endfunction : rnd
  // Expected reply: identifier, count or data, payload
  function automatic void add_rsp(input logic gn, input int k,
      input logic [63:0] d);
    logic [5:0] dt;
    if (k > 2) begin
      dt = gn ? 6'h1a : 6'h1c;
      expq.push_back({4'h8, dt});
      expq.push_back({2'h0, 8'(k)});
      expq.push_back(10'h000);
      for (int j = 0; j < k; j++) expq.push_back({1'b0, j == k - 1, d[8*j+:8]});
    end else begin
      dt = k == 1 ? (gn ? 6'h11 : 6'h21) : (gn ? 6'h12 : 6'h22);
      expq.push_back({4'h8, dt});
      expq.push_back({2'h0, d[7:0]});
      expq.push_back({2'h1, k == 1 ? 8'h00 : d[15:8]});
    end
  endfunction : add_rsp
  function automatic void add_ack(input logic [15:0] rp);
    expq.push_back(10'h202);
    expq.push_back({2'h0, rp[7:0]});
    expq.push_back({2'h1, rp[15:8]});
  endfunction : add_ack
  function automatic logic [24:0] exp_pix(input logic f, input logic [23:0] p);
    if (f) return {3'h4, p[7:2], 2'h0, p[15:10], 2'h0, p[23:18]};
    return {1'b0, p[7:0], p[15:8], p[23:16]};
  endfunction : exp_pix

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic pkt(input logic [5:0] dt, input int k, input logic lp,
      input logic [15:0] e, input logic bad);
    u_host.send_pkt({2'h0, dt, 16'(k), lp}, e, dat, bad);
  endtask : pkt
  // One request pulse, wait for idle, compare bytes taken
  task automatic request(input logic gn, input int k, input logic ak);
    int w;
    @(posedge core_clk_i);
    #1;
    rsp_req_i = !ak;
    ack_req_i = ak;
    rsp_generic_i = gn;
    rsp_len_i = 4'(k);
    rsp_data_i = dat;
    @(posedge core_clk_i);
    #1;
    rsp_req_i = 1'b0;
    ack_req_i = 1'b0;
    w = 0;
    while (rsp_busy_o === 1'b1 && w < 400) begin
      @(posedge core_clk_i);
      w++;
    end
    #1;
    check("busy end", rsp_busy_o, 0);
    check("tx bytes", txq.size(), expq.size());
    foreach (expq[j]) if (j < txq.size()) check("tx byte", txq[j], expq[j]);
    txq.delete();
    expq.delete();
  endtask : request
  task automatic clear_cnt();
    @(posedge core_clk_i);
    #1;
    cnt_read_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    cnt_read_i = 1'b0;
    check("cleared", {err_flag_o, err_count_o}, 0);
  endtask : clear_cnt
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the expected run
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
  // Main sequence; reset is longer than four link cycles for the link sync
  initial begin
    {rst_i, rsp_req_i, ack_req_i, cnt_read_i, rsp_generic_i, slow} = 6'h20;
    rsp_len_i = 4'h0;
    rsp_data_i = 64'h0;
    dat = 64'h0;
    repeat (40) @(posedge core_clk_i);
    check("reset outs", {tx_valid_o, rsp_busy_o, err_flag_o, err_count_o,
      err_report_o}, 0);
    #1 rst_i = 1'b0;
    repeat (6) @(posedge link_clk_i);
    for (b = 0; b < 16; b++) begin
      pkt(6'h06, 2, 1'b0, 16'h1 << b, 1'b0);
      r = (16'h1 << b) & 16'hbbff;
      check("report", err_report_o, r);
      add_ack(r);
      request(1'b0, 0, 1'b1);
    end
    check("flag", err_flag_o, 1);
    check("count", err_count_o, 2);
    pkt(6'h29, 3, 1'b1, 16'h0, 1'b1);
    check("crc report", err_report_o, 16'h0400);
    check("crc count", err_count_o, 3);
    pkt(6'h06, 2, 1'b0, 16'h0, 1'b0);
    check("clean report", err_report_o, 0);
    pkt(6'h06, 2, 1'b0, 16'h0100, 1'b0);
    dat = {rnd(), rnd()};
    add_rsp(1'b0, 2, dat);
    add_ack(16'h0100);
    request(1'b0, 2, 1'b0);
    clear_cnt();
    // Clean packet first, else every read below trails a report
    pkt(6'h06, 2, 1'b0, 16'h0, 1'b0);
    check("report renew", err_report_o, 0);
    for (g = 0; g < 2; g++) for (n = 1; n <= 8; n++) begin
      slow = n[0];
      dat = {rnd(), rnd()};
      add_rsp(g[0], n, dat);
      request(g[0], n, 1'b0);
    end
    for (g = 0; g < 2; g++) begin
      dat = {rnd(), rnd()};
      pkt(g ? 6'h1e : 6'h3e, 6, 1'b1, 16'h0, 1'b0);
      check("pixels", pixq.size(), 2);
      for (i = 0; i < 2 && i < pixq.size(); i++)
        check("pixel", pixq[i], exp_pix(g[0], dat[24*i+:24]));
      pixq.delete();
    end
    pkt(6'h3e, 6, 1'b1, 16'h0200, 1'b0);
    check("discarded", pixq.size(), 0);
    pkt(6'h3e, 6, 1'b1, 16'h0, 1'b1);
    check("drop pulse", n_drop, 1);
    for (i = 0; i < 260; i++) pkt(6'h06, 2, 1'b0, 16'h0200, 1'b0);
    check("saturated", err_count_o, 8'hff);
    clear_cnt();
    print_verdict();
  end
endmodule : tb_top
